// *** include/ssf_pkg.sv ***
// constants for the serial port slave status flags block
package ssf_pkg;
  // consecutive synced samples before the filtered select follows the pin
  localparam int unsigned DEGLITCH_CYCLES = 3;
  localparam int unsigned DGL_CNT_W = 2;
  // serial clock edges per byte (two per bit, eight bits)
  localparam int unsigned EDGE_CNT_W = 4;
  // master bit counter width and divider width
  localparam int unsigned MCNT_W = 9;
  localparam int unsigned DIV_W = 8;
  // synchroniser lanes: slave select, serial clock, mosi, miso
  localparam int unsigned SYNC_W = 4;
  localparam int unsigned LANE_NSS = 0;
  localparam int unsigned LANE_SCK = 1;
  localparam int unsigned LANE_MOSI = 2;
  localparam int unsigned LANE_MISO = 3;
  // values after reset
  localparam logic RST_SELECTED = 1'b0;
  localparam logic RST_RAW_LEVEL = 1'b1;
  localparam logic RST_SHIFT_EMPTY = 1'b1;
  localparam logic RST_RX_EMPTY = 1'b1;
  localparam logic [SYNC_W-1:0] RST_SYNC = 4'h3;
endpackage

// *** rtl/ssf_sync.sv ***
// two-flop synchroniser for asynchronous pin inputs
module ssf_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] data_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_q <= RST_VAL;
      data_o <= RST_VAL;
    end else begin
      meta_q <= data_i;
      data_o <= meta_q;
    end
  end
endmodule

// *** rtl/ssf_status.sv ***
// slave-mode status flags and data sampling of the serial peripheral port
// What this block does
// - filtered select low sets slave-selected flag
// - filtered select high clears slave-selected flag
// - slave-selected follows a de-glitched select copy
// - raw select level reports unfiltered pin
// - shift empty set when idle, buffers quiet
// - tx load or clock edge clears shift empty
// - master mode forces shift empty to one
// - rx read with no new byte sets empty
// - unread receive byte clears receive empty
// - master mode forces receive empty to one
// - slave samples mosi at bit centre
// - master samples miso one cycle before bit end
module ssf_status (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // pins from the external master, miso from the external slave
  input wire logic slave_select_in_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  // configuration
  input wire logic master_mode_i,
  input wire logic clk_phase_i,
  input wire logic [ssf_pkg::DIV_W-1:0] master_half_div_i,
  // datapath status, same clock
  input wire logic tx_load_i,
  input wire logic tx_buf_full_i,
  input wire logic rx_pending_i,
  input wire logic rx_full_i,
  input wire logic rx_read_i,
  input wire logic master_bit_start_i,
  input wire logic master_busy_i,
  // status flags
  output logic slave_selected_o,
  output logic raw_select_level_o,
  output logic shift_empty_flag_o,
  output logic rx_buffer_empty_flag_o,
  // sampled serial data
  output logic sample_bit_o,
  output logic sample_strobe_o
);
  logic [ssf_pkg::SYNC_W-1:0] pins_s;
  logic nss_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic sck_prev_q;
  logic sck_edge;
  logic slave_sample;
  logic master_sample;
  logic [ssf_pkg::DGL_CNT_W-1:0] dgl_cnt_q;
  logic [ssf_pkg::EDGE_CNT_W-1:0] edge_cnt_q;
  logic [ssf_pkg::MCNT_W-1:0] mcnt_q;
  logic [ssf_pkg::MCNT_W-1:0] m_period;

  // pins synchronised before any use
  ssf_sync #(
    .W(ssf_pkg::SYNC_W),
    .RST_VAL(ssf_pkg::RST_SYNC)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .data_i({miso_i, mosi_i, sck_i, slave_select_in_i}),
    .data_o(pins_s)
  );

  assign nss_s = pins_s[ssf_pkg::LANE_NSS];
  assign sck_s = pins_s[ssf_pkg::LANE_SCK];
  assign mosi_s = pins_s[ssf_pkg::LANE_MOSI];
  assign miso_s = pins_s[ssf_pkg::LANE_MISO];

  // de-glitch filter on the select line
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dgl_cnt_q <= '0;
      slave_selected_o <= ssf_pkg::RST_SELECTED;
    end else if (nss_s == slave_selected_o) begin
      if (dgl_cnt_q == ssf_pkg::DGL_CNT_W'(ssf_pkg::DEGLITCH_CYCLES - 1)) begin
        dgl_cnt_q <= '0;
        slave_selected_o <= ~nss_s;
      end else begin
        dgl_cnt_q <= dgl_cnt_q + 1'b1;
      end
    end else begin
      dgl_cnt_q <= '0;
    end
  end

  // raw select level, no filter
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      raw_select_level_o <= ssf_pkg::RST_RAW_LEVEL;
    end else begin
      raw_select_level_o <= nss_s;
    end
  end

  // serial clock edge detection
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sck_prev_q <= ssf_pkg::RST_SYNC[ssf_pkg::LANE_SCK];
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  assign sck_edge = sck_s ^ sck_prev_q;
  // opposite edge to the launch edge is the bit centre
  assign slave_sample = slave_selected_o && !master_mode_i && sck_edge &&
                        (sck_s ^ clk_phase_i);

  // edges within the current byte
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !slave_selected_o) begin
      edge_cnt_q <= '0;
    end else if (sck_edge) begin
      edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

  // shift register empty flag
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      shift_empty_flag_o <= ssf_pkg::RST_SHIFT_EMPTY;
    end else if (master_mode_i) begin
      shift_empty_flag_o <= 1'b1;
    end else if (tx_load_i || sck_edge) begin
      shift_empty_flag_o <= 1'b0;
    end else if (edge_cnt_q == '0 && !tx_buf_full_i && !rx_pending_i) begin
      shift_empty_flag_o <= 1'b1;
    end
  end

  // receive buffer empty flag
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_buffer_empty_flag_o <= ssf_pkg::RST_RX_EMPTY;
    end else if (master_mode_i) begin
      rx_buffer_empty_flag_o <= 1'b1;
    end else if (rx_full_i) begin
      rx_buffer_empty_flag_o <= 1'b0;
    end else if (rx_read_i) begin
      rx_buffer_empty_flag_o <= 1'b1;
    end
  end

  // master bit timer
  assign m_period = {master_half_div_i, 1'b0} + ssf_pkg::MCNT_W'(2);
  assign master_sample = master_mode_i && master_busy_i &&
                         (mcnt_q == m_period - ssf_pkg::MCNT_W'(2));

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || master_bit_start_i) begin
      mcnt_q <= '0;
    end else if (master_busy_i) begin
      if (mcnt_q >= m_period - ssf_pkg::MCNT_W'(1)) begin
        mcnt_q <= '0;
      end else begin
        mcnt_q <= mcnt_q + 1'b1;
      end
    end
  end

  // data sampling
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sample_bit_o <= 1'b0;
      sample_strobe_o <= 1'b0;
    end else begin
      sample_strobe_o <= slave_sample || master_sample;
      if (slave_sample) begin
        sample_bit_o <= mosi_s;
      end else if (master_sample) begin
        sample_bit_o <= miso_s;
      end
    end
  end

  a_sel_low: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!nss_s)[*3] |=> slave_selected_o)
    else $error("select low three cycles did not set selected");

  a_sel_high: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    nss_s[*3] |=> !slave_selected_o)
    else $error("select high three cycles did not clear selected");

  a_sel_glitch: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (slave_selected_o && !nss_s) ##1 nss_s |=> slave_selected_o)
    else $error("single glitch changed selected");

  a_raw_level: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ##1 raw_select_level_o == $past(nss_s))
    else $error("raw level does not follow synced pin");

  a_shift_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!master_mode_i && !tx_load_i && !sck_edge && edge_cnt_q == '0 &&
     !tx_buf_full_i && !rx_pending_i) |=> shift_empty_flag_o)
    else $error("shift empty not set when idle");

  a_shift_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!master_mode_i && (tx_load_i || sck_edge)) |=> !shift_empty_flag_o)
    else $error("shift empty not cleared");

  a_master_shift: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_mode_i[*2] |-> shift_empty_flag_o)
    else $error("shift empty not one in master mode");

  a_rx_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!master_mode_i && !rx_full_i && rx_read_i) |=> rx_buffer_empty_flag_o)
    else $error("receive empty not set after read");

  a_rx_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!master_mode_i && rx_full_i) |=> !rx_buffer_empty_flag_o)
    else $error("receive empty not cleared with unread byte");

  a_master_rx: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_mode_i |=> rx_buffer_empty_flag_o)
    else $error("receive empty not one in master mode");

  a_slave_sample: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    slave_sample |=> sample_strobe_o && sample_bit_o == $past(mosi_s))
    else $error("slave sample missed mosi");

  a_master_sample: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    master_sample |=> sample_strobe_o && sample_bit_o == $past(miso_s) &&
    (mcnt_q == m_period - ssf_pkg::MCNT_W'(1)))
    else $error("master sample not one cycle before bit end");
endmodule

// *** test/ssf_master_model.sv ***
// external serial master: select, clock and data
module ssf_master_model (
  // pins toward the slave
  output logic nss_o,
  output logic sck_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    nss_o = 1'b1;
    sck_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic set_sel(input logic lvl);
    nss_o = lvl;
  endtask
  // msb first, 80 ns bit; phase 0 launches on fall, phase 1 on rise
  task automatic send_byte(input logic [7:0] b, input logic ph);
    for (int i = 7; i >= 0; i--) begin
      if (ph) begin
        mosi_o = b[i];
        #40;
        sck_o = 1'b0;
        #40;
        sck_o = 1'b1;
      end else begin
        sck_o = 1'b0;
        mosi_o = b[i];
        #40;
        sck_o = 1'b1;
        #40;
      end
    end
    // released line shows inverse
    mosi_o = ~mosi_o;
  endtask
endmodule

// *** test/tb_ssf_status.sv ***
// self-checking bench for the slave status flags
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t got %h exp %h", $time, (a), (e)); end end
module tb_ssf_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, srst_i = 1, miso = 0, mm = 0, ph = 0, ld = 0, tf = 0;
  logic pd = 0, rf = 0, rd = 0, bs = 0, bz = 0, m;
  logic [ssf_pkg::DIV_W-1:0] dv = 8'h01;
  wire logic slave_select_in, sck, mosi;
  logic sel, raw, se, re, sb, st;
  logic [7:0] got = 8'h00, b;
  int nstb = 0, n0 = 0, error_cnt = 0, num_checks = 0;
  initial forever #4 ref_clk_i = ~ref_clk_i;
  ssf_master_model u_master (.nss_o(slave_select_in), .sck_o(sck), .mosi_o(mosi));
  ssf_status u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .slave_select_in_i(slave_select_in),
    .sck_i(sck), .mosi_i(mosi), .miso_i(miso), .master_mode_i(mm), .clk_phase_i(ph),
    .master_half_div_i(dv), .tx_load_i(ld), .tx_buf_full_i(tf), .rx_pending_i(pd),
    .rx_full_i(rf), .rx_read_i(rd), .master_bit_start_i(bs), .master_busy_i(bz),
    .slave_selected_o(sel), .raw_select_level_o(raw), .shift_empty_flag_o(se),
    .rx_buffer_empty_flag_o(re), .sample_bit_o(sb), .sample_strobe_o(st));
  always @(posedge ref_clk_i) begin
    if (st === 1'b1) begin
      got <= {got[6:0], sb};
      nstb <= nstb + 1;
    end
  end
  function automatic logic exp_se(input logic full, input logic pend);
    return ~(full | pend);
  endfunction
  task automatic nw(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #50us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h8565));
    nw(5);
    srst_i = 1'b0;
    `CHK(sel, 1'b0)
    `CHK(raw, 1'b1)
    `CHK(se, 1'b1)
    `CHK(re, 1'b1)
    nw(1);
    `CHK(se, 1'b1)
    $display("reset test done");
    u_master.set_sel(1'b0);
    nw(2);
    u_master.set_sel(1'b1);
    nw(10);
    `CHK(sel, 1'b0)
    u_master.set_sel(1'b0);
    nw(4);
    `CHK(raw, 1'b0)
    `CHK(sel, 1'b0)
    nw(4);
    `CHK(sel, 1'b1)
    u_master.set_sel(1'b1);
    nw(1);
    u_master.set_sel(1'b0);
    nw(8);
    `CHK(sel, 1'b1)
    $display("select test done");
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      tf = (k == 2);
      pd = (k == 3);
      ph = k[0];
      fork
        u_master.send_byte(b, ph);
        begin #98; `CHK(se, 1'b0) end
      join
      nw(8);
      `CHK(got, b)
      `CHK(se, exp_se(tf, pd))
      tf = 1'b0;
      pd = 1'b0;
      nw(2);
      `CHK(se, 1'b1)
    end
    $display("frame test done");
    ld = 1'b1;
    nw(1);
    ld = 1'b0;
    `CHK(se, 1'b0)
    nw(2);
    `CHK(se, 1'b1)
    rf = 1'b1;
    rd = 1'b1;
    nw(2);
    `CHK(re, 1'b0)
    rf = 1'b0;
    nw(1);
    rd = 1'b0;
    `CHK(re, 1'b1)
    $display("buffer test done");
    u_master.set_sel(1'b1);
    nw(8);
    `CHK(sel, 1'b0)
    rf = 1'b1;
    tf = 1'b1;
    ld = 1'b1;
    nw(1);
    ld = 1'b0;
    `CHK(se, 1'b0)
    `CHK(re, 1'b0)
    mm = 1'b1;
    nw(1);
    `CHK(se, 1'b1)
    `CHK(re, 1'b1)
    for (int j = 0; j < 2; j++) begin
      m = 1'($urandom) ^ 1'(j);
      miso = m;
      bz = 1'b1;
      nw(4);
      bs = 1'b1;
      nw(1);
      bs = 1'b0;
      nw(4);
      n0 = nstb;
      nw(16);
      `CHK(nstb - n0, 4)
      `CHK(sb, m)
    end
    $display("master test done");
    tally_and_finish();
  end
endmodule
